// [logic/spims_core.v]
// serial peripheral core, master or slave, with status flags
//
// Overview of operation
// R01: master drives sck at selected rate
// R02: idle sck rests at polarity level
// R03: software sets select before master, enable
// R04: master, enable kept only while select high
// R05: master data write loads, shifts msb first
// R06: byte end sets done flag, interrupt request
// R07: done cleared by status access then data; code clears on a data read, or a data write as slave only
// R08: data writes ignored while done, status unread
// R09: partner keeps slave select per phase
// R10: slave write loads, shifts on master clock
// R11: slave software clears done before next end
// R12: polarity, phase pick the capture edge
// R13: software disables before polarity change
// R14: select low as master faults, drops bits
// R15: fault cleared by status read, control write
// R16: fault refuses setting master, enable bits
// R17: slave never sets the fault flag
// R18: byte end while done set gives overrun
// R19: overrun keeps first byte, drops later
// R20: overrun cleared by status read
// R21: data write while busy collides, dropped
// R22: data write never clears collision flag
// R23: collision cleared by status, data read
// R24: soft select follows software level bit
// R25: phase zero slave without select gap collides
`timescale 1ns/1ps
`include "spims_map.vh"
module spims_core #(
    parameter DATA_W = `SPIMS_DATA_W
) (
    input wire core_clk_i,
    input wire rst_i,
    // configuration bits, held by software
    input wire [2:0] clock_rate_select_i,
    input wire clock_idle_polarity_i,
    input wire clock_sample_phase_i,
    input wire select_soft_manage_i,
    input wire select_soft_level_i,
    input wire irq_enable_bit_i,
    input wire cpu_mask_i,
    // control register write with its two stored bits
    input wire ctrl_wr_i,
    input wire master_select_wr_i,
    input wire peripheral_enable_wr_i,
    // status register access strobes
    input wire status_rd_i,
    input wire status_wr_i,
    // data register access
    input wire data_wr_i,
    input wire [DATA_W-1:0] data_wdata_i,
    input wire data_rd_i,
    output wire [DATA_W-1:0] data_rdata_o,
    // stored control bits and flags, then interrupt request and busy
    output wire master_select_bit_o,
    output wire peripheral_enable_bit_o,
    output wire transfer_done_flag_o,
    output wire mode_fault_flag_o,
    output wire overrun_flag_o,
    output wire write_collision_flag_o,
    output wire irq_req_o,
    output wire busy_o,
    // serial pins, each two-way pin split in three
    input wire sck_i,
    output wire sck_o,
    output wire sck_oe_o,
    input wire mosi_i,
    output wire mosi_o,
    output wire mosi_oe_o,
    input wire miso_i,
    output wire miso_o,
    output wire miso_oe_o,
    input wire select_n_i
);
    localparam M_IDLE = 1'b0; // master not shifting
    localparam M_RUN = 1'b1; // master clocking a byte

    // pin synchronisers: order sck, mosi, miso, select
    reg [3:0] pin_s1_r; // first stage, read only by second
    reg [3:0] pin_s2_r; // second stage, safe to use
    reg sck_prev_r; // last synced sck for edge finding

    // stored control bits and flags
    reg master_select_bit_r;
    reg spe_r;
    reg done_r;
    reg done_arm_r; // status accessed while done set
    reg fault_r;
    reg fault_arm_r; // status read while fault set
    reg ovr_r;
    reg write_collision_flag_r;
    reg write_collision_flag_arm_r; // status read seen, data read clears
    reg [DATA_W-1:0] rx_r; // receive buffer

    // transfer engine
    reg mst_state_r;
    reg [7:0] div_cnt_r; // half period counter
    reg sck_lvl_r; // master clock level
    reg [2:0] bit_cnt_r; // trailing edges seen this byte
    reg in_latch_r; // bit taken on the capture edge
    reg end_q_r; // byte ended last cycle
    reg sl_byte_r; // slave ended a byte since select fell

    wire [DATA_W-1:0] sh_data;
    wire sh_out;

    wire sck_s = pin_s2_r[0];
    wire mosi_s = pin_s2_r[1];
    wire miso_s = pin_s2_r[2];
    // internal select level, soft or from the pin
    wire sel_lvl = select_soft_manage_i ? select_soft_level_i : pin_s2_r[3]; // R24

    // clipped rate and master half period
    wire [2:0] rate = (clock_rate_select_i > `SPIMS_RATE_MAX) ? `SPIMS_RATE_MAX : clock_rate_select_i;
    wire [7:0] half_lim = (`SPIMS_DIV_BASE << rate) - 8'h01; // R01

    wire master_on = master_select_bit_r && spe_r;
    wire slave_on = !master_select_bit_r && spe_r && !sel_lvl;

    // master edges, one when the half period runs out
    wire m_tick = (mst_state_r == M_RUN) && (div_cnt_r == half_lim);
    wire m_lead = m_tick && (sck_lvl_r == clock_idle_polarity_i);
    wire m_trail = m_tick && (sck_lvl_r != clock_idle_polarity_i);
    // slave edges, found on the synced clock
    wire s_chg = slave_on && (sck_s != sck_prev_r);
    wire s_lead = s_chg && (sck_prev_r == clock_idle_polarity_i);
    wire s_trail = s_chg && (sck_prev_r != clock_idle_polarity_i);

    wire lead_ev = m_lead || s_lead;
    wire trail_ev = m_trail || s_trail;
    wire last_bit = (bit_cnt_r == `SPIMS_LAST_BIT);
    // phase picks which edge captures and which moves data
    wire cap_ev = clock_sample_phase_i ? trail_ev : lead_ev; // R12
    // phase one keeps its last bit in the latch, so mosi never moves on a capture edge
    wire shift_ev = clock_sample_phase_i ? (lead_ev && (bit_cnt_r != 3'h0)) : trail_ev; // R12
    wire din = master_select_bit_r ? miso_s : mosi_s;
    // a capture and a shift together take the fresh bit
    wire shift_in = cap_ev ? din : in_latch_r;
    wire byte_end = trail_ev && last_bit;

    // slave is busy mid byte, or in phase zero until select rises
    wire sl_busy = slave_on && ((bit_cnt_r != 3'h0) || (!clock_sample_phase_i && sl_byte_r)); // R25
    wire busy = (mst_state_r == M_RUN) || end_q_r || sl_busy;

    // data write filtering
    wire wr_block = data_wr_i && done_r && !done_arm_r; // R08
    wire wr_coll = data_wr_i && !wr_block && busy; // R21
    wire wr_ok = data_wr_i && !wr_block && !busy;
    wire m_start = wr_ok && master_on && (mst_state_r == M_IDLE); // R05

    // flag clearing terms
    wire status_acc = status_rd_i || status_wr_i;
    wire done_clr = done_arm_r && (data_rd_i || (!master_select_bit_r && data_wr_i)); // R07
    wire fault_clr = fault_arm_r && ctrl_wr_i; // R15
    // select low while master is a fault, never as slave
    wire fault_ev = master_select_bit_r && !sel_lvl; // R14 R17 R04
    wire ovr_ev = end_q_r && done_r && !done_clr; // R18

    // pin synchronisers
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_s1_r <= 4'hf;
            pin_s2_r <= 4'hf;
            sck_prev_r <= 1'b1; // matches the synced reset level, no false edge
        end else begin
            pin_s1_r <= {select_n_i, miso_i, mosi_i, sck_i};
            pin_s2_r <= pin_s1_r;
            sck_prev_r <= pin_s2_r[0];
        end
    end

    // control bits: fault drops both, fault refuses setting them
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            master_select_bit_r <= `SPIMS_MASTER_SELECT_BIT_RST;
            spe_r <= `SPIMS_SPE_RST;
        end else if (fault_ev) begin
            master_select_bit_r <= 1'b0; // R14
            spe_r <= 1'b0; // R14
        end else if (ctrl_wr_i) begin
            // while faulted only the clearing write may set them
            if (fault_r && !fault_arm_r) begin
                master_select_bit_r <= master_select_bit_r && master_select_wr_i; // R16
                spe_r <= spe_r && peripheral_enable_wr_i; // R16
            end else begin
                master_select_bit_r <= master_select_wr_i;
                spe_r <= peripheral_enable_wr_i;
            end
        end
    end

    // mode fault flag, set wins over its clearing write
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            fault_r <= `SPIMS_FLAG_RST;
            fault_arm_r <= 1'b0;
        end else begin
            if (fault_ev) begin
                fault_r <= 1'b1; // R14
            end else if (fault_clr) begin
                fault_r <= 1'b0; // R15
            end
            // arming needs a status read while set
            if (fault_clr || fault_ev) begin
                fault_arm_r <= 1'b0;
            end else if (status_rd_i && fault_r) begin
                fault_arm_r <= 1'b1; // R15
            end
        end
    end

    // transfer done flag and its two step clear
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            done_r <= `SPIMS_FLAG_RST;
            done_arm_r <= 1'b0;
        end else begin
            if (end_q_r) begin
                done_r <= 1'b1; // R06
            end else if (done_clr) begin
                done_r <= 1'b0; // R07
            end
            // a new byte end makes the old access stale
            if (end_q_r || done_clr) begin
                done_arm_r <= 1'b0;
            end else if (status_acc && done_r) begin
                done_arm_r <= 1'b1; // R07 R08
            end
        end
    end

    // overrun flag, cleared by a status read; set wins
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            ovr_r <= `SPIMS_FLAG_RST;
        end else if (ovr_ev) begin
            ovr_r <= 1'b1; // R18
        end else if (status_rd_i) begin
            ovr_r <= 1'b0; // R20
        end
    end

    // write collision flag, only a status then data read clears it
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            write_collision_flag_r <= `SPIMS_FLAG_RST;
            write_collision_flag_arm_r <= 1'b0;
        end else begin
            if (wr_coll) begin
                write_collision_flag_r <= 1'b1; // R21
            end else if (write_collision_flag_arm_r && data_rd_i) begin
                write_collision_flag_r <= 1'b0; // R23 R22
            end
            // a colliding data write drops the arming, other data writes leave it alone
            if (wr_coll || (write_collision_flag_arm_r && data_rd_i)) begin
                write_collision_flag_arm_r <= 1'b0;
            end else if (status_rd_i) begin
                write_collision_flag_arm_r <= 1'b1; // R23
            end
        end
    end

    // receive buffer keeps the first byte after the last clear
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            rx_r <= `SPIMS_BYTE_RST;
        end else if (end_q_r && !ovr_ev) begin
            // phase one appends the bit still held in the capture latch
            rx_r <= clock_sample_phase_i ? {sh_data[DATA_W-2:0], in_latch_r} : sh_data; // R19
        end
    end

    // master clock generator
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            mst_state_r <= M_IDLE;
            div_cnt_r <= 8'h00;
            sck_lvl_r <= 1'b0;
        end else begin
            case (mst_state_r)
                M_IDLE: begin
                    div_cnt_r <= 8'h00;
                    sck_lvl_r <= clock_idle_polarity_i; // R02
                    if (m_start) begin
                        mst_state_r <= M_RUN; // R05
                    end
                end
                M_RUN: begin
                    // a fault or disable stops the byte at once
                    if (!master_on || fault_ev) begin
                        mst_state_r <= M_IDLE;
                    end else if (m_tick) begin
                        div_cnt_r <= 8'h00;
                        sck_lvl_r <= !sck_lvl_r; // R01
                        if (byte_end) begin
                            mst_state_r <= M_IDLE;
                        end
                    end else begin
                        div_cnt_r <= div_cnt_r + 8'h01;
                    end
                end
                default: begin
                    mst_state_r <= M_IDLE;
                end
            endcase
        end
    end

    // bit counter, capture latch and byte end pulse
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            bit_cnt_r <= 3'h0;
            in_latch_r <= 1'b0;
            end_q_r <= 1'b0;
            sl_byte_r <= 1'b0;
        end else begin
            end_q_r <= byte_end; // R06
            if (cap_ev) begin
                in_latch_r <= din; // R12
            end
            // slave select high restarts the slave byte
            if (!master_select_bit_r && sel_lvl) begin
                bit_cnt_r <= 3'h0;
            end else if (trail_ev) begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
            end
            // phase zero slave needs select high between bytes
            if (sel_lvl || master_select_bit_r) begin
                sl_byte_r <= 1'b0;
            end else if (s_trail && last_bit) begin
                sl_byte_r <= 1'b1; // R25
            end
        end
    end

    // the byte in flight
    spims_shift #(
        .WIDTH(DATA_W)
    ) u_shift (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .load_i(wr_ok), // R05 R10
        .load_data_i(data_wdata_i),
        .shift_i(shift_ev), // R10
        .in_bit_i(shift_in),
        .out_bit_o(sh_out),
        .data_o(sh_data)
    );

    // pins: disabled core drives nothing
    assign sck_o = (mst_state_r == M_RUN) ? sck_lvl_r : clock_idle_polarity_i; // R02
    assign sck_oe_o = master_on; // R01
    assign mosi_o = sh_out; // R05
    assign mosi_oe_o = master_on;
    assign miso_o = sh_out; // R10
    assign miso_oe_o = slave_on;

    // software view
    assign data_rdata_o = rx_r;
    assign master_select_bit_o = master_select_bit_r;
    assign peripheral_enable_bit_o = spe_r;
    assign transfer_done_flag_o = done_r;
    assign mode_fault_flag_o = fault_r;
    assign overrun_flag_o = ovr_r;
    assign write_collision_flag_o = write_collision_flag_r;
    assign busy_o = busy;
    // collision alone never requests
    assign irq_req_o = irq_enable_bit_i && !cpu_mask_i && (done_r || fault_r || ovr_r); // R06 R14 R18
endmodule

// [common/spims_map.vh]
// constants for the serial master/slave core
`ifndef SPIMS_MAP_VH
`define SPIMS_MAP_VH
// data width of one transfer
`define SPIMS_DATA_W 8
// master half period is DIV_BASE << rate cycles (rate 0 gives cpu/4)
`define SPIMS_DIV_BASE 8'h02
// highest rate code, larger codes are clipped to it
`define SPIMS_RATE_MAX 3'h5
// last bit index of a byte
`define SPIMS_LAST_BIT 3'h7
// reset values of the stored control bits and flags
`define SPIMS_MASTER_SELECT_BIT_RST 1'b0
`define SPIMS_SPE_RST 1'b0
`define SPIMS_FLAG_RST 1'b0
`define SPIMS_BYTE_RST 8'h00
`endif

// [logic/spims_shift.v]
// shift register holding the byte in flight, msb first
`timescale 1ns/1ps
module spims_shift #(
    parameter WIDTH = 8
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire load_i, // parallel load from software
    input wire [WIDTH-1:0] load_data_i,
    input wire shift_i, // advance one bit
    input wire in_bit_i, // bit entering at the lsb
    output wire out_bit_o, // bit currently on the line
    output wire [WIDTH-1:0] data_o // whole register
);
    reg [WIDTH-1:0] sh_r; // the shift register
    reg [WIDTH-1:0] sh_nxt;

    // next value: load beats shift; a phase zero slave can ask both at its first trailing edge
    always @* begin
        sh_nxt = sh_r;
        if (load_i) begin
            sh_nxt = load_data_i;
        end else if (shift_i) begin
            sh_nxt = {sh_r[WIDTH-2:0], in_bit_i};
        end
    end

    // storage
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            sh_r <= {WIDTH{1'b0}};
        end else begin
            sh_r <= sh_nxt;
        end
    end

    assign out_bit_o = sh_r[WIDTH-1];
    assign data_o = sh_r;
endmodule

// [sim/spims_core_sva.sv]
// port assertions for the serial master/slave core
`timescale 1ns/1ps
module spims_chk (
    input wire core_clk_i,
    input wire rst_i,
    input wire clock_idle_polarity_i,
    input wire select_soft_manage_i,
    input wire select_soft_level_i,
    input wire irq_enable_bit_i,
    input wire cpu_mask_i,
    input wire status_rd_i,
    input wire data_wr_i,
    input wire data_rd_i,
    input wire master_select_bit_o,
    input wire peripheral_enable_bit_o,
    input wire transfer_done_flag_o,
    input wire mode_fault_flag_o,
    input wire overrun_flag_o,
    input wire write_collision_flag_o,
    input wire irq_req_o,
    input wire busy_o,
    input wire sck_o,
    input wire sck_oe_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    reg armed_r; // status read seen while fault stands
    // arming of the fault clear, dropped once the fault is gone
    always @(posedge core_clk_i) begin
        if (rst_i || !mode_fault_flag_o)
            armed_r <= 1'b0;
        else if (status_rd_i)
            armed_r <= 1'b1;
    end
    sck_idle_a:
        assert property (sck_oe_o && !busy_o |-> sck_o == clock_idle_polarity_i) else $error("sck off idle");
    fault_set_a:
        assert property (master_select_bit_o && select_soft_manage_i && !select_soft_level_i
            |=> mode_fault_flag_o && !master_select_bit_o && !peripheral_enable_bit_o) else $error("no fault");
    slave_nofault_a:
        assert property (!master_select_bit_o && !mode_fault_flag_o |=> !mode_fault_flag_o) else $error("slave fault");
    irq_map_a:
        assert property (irq_req_o == (irq_enable_bit_i && !cpu_mask_i
            && (transfer_done_flag_o || mode_fault_flag_o || overrun_flag_o))) else $error("irq wrong");
    busy_collide_a:
        assert property (data_wr_i && busy_o && !transfer_done_flag_o |=> write_collision_flag_o)
        else $error("no collision");
    write_collision_flag_keep_a:
        assert property (write_collision_flag_o && !data_rd_i |=> write_collision_flag_o) else $error("write_collision_flag lost");
    ovr_cause_a:
        assert property ($rose(overrun_flag_o) |-> $past(transfer_done_flag_o)) else $error("stray overrun");
    ovr_clear_a:
        assert property (overrun_flag_o && status_rd_i && !busy_o |=> !overrun_flag_o) else $error("ovr kept");
    done_keep_a:
        assert property (transfer_done_flag_o && !data_rd_i && !data_wr_i |=> transfer_done_flag_o)
        else $error("done lost");
    fault_refuse_a:
        assert property (mode_fault_flag_o && !armed_r && !master_select_bit_o && !peripheral_enable_bit_o
            |=> !master_select_bit_o && !peripheral_enable_bit_o) else $error("bits set in fault");
endmodule
bind spims_core spims_chk u_chk (.*);

// [sim/spims_peer.sv]
// far side model: spi master driving the pins, or slave answering
`timescale 1ns/1ps
module spims_peer (
    input wire sck_w,
    input wire mosi_w,
    input wire miso_w,
    output reg sck_o = 1'h0,
    output reg mosi_o = 1'h0,
    output wire miso_o,
    output reg sel_n_o = 1'h1
);
    reg clock_idle_polarity = 1'h0, clock_sample_phase = 1'h0, slv_on = 1'h0; // timing mode, slave role
    reg [7:0] stx = 8'h00, srx = 8'h00; // slave out and captured bytes
    integer cnt = 0; // captures in this byte
    assign miso_o = stx[7]; // msb first
    // slave role: capture on the phase edge, shift on the other
    always @(sck_w) begin
        if (slv_on && ((sck_w != clock_idle_polarity) ^ clock_sample_phase)) begin
            srx = {srx[6:0], mosi_w};
            cnt = cnt + 1;
        end else if (slv_on && cnt != 0) begin
            stx = {stx[6:0], ~stx[0]}; // tail bits keep changing
        end
    end
    task setup(input p, input h, input s);
        clock_idle_polarity = p;
        clock_sample_phase = h;
        slv_on = s;
        sck_o = p;
    endtask
    task load(input [7:0] b);
        stx = b;
        cnt = 0;
    endtask
    // master role: one byte at 200 ns per clock
    task xfer(input [7:0] tx, input hold, output [7:0] rx);
        integer i;
        sel_n_o = 1'h0;
        mosi_o = tx[7];
        #100;
        for (i = 7; i >= 0; i = i - 1) begin
            sck_o = ~clock_idle_polarity;
            if (clock_sample_phase)
                mosi_o = tx[i];
            else
                rx[i] = miso_w;
            #100;
            sck_o = clock_idle_polarity;
            if (clock_sample_phase)
                rx[i] = miso_w;
            else if (i > 0)
                mosi_o = tx[i-1];
            #100;
        end
        sel_n_o = hold;
        mosi_o = ~mosi_o; // released line never shows the last bit
    endtask
endmodule

// [sim/spi_master_slave_core_tb_top.sv]
// self-checking bench for the serial core against the far side model
`timescale 1ns/1ps
module spi_master_slave_core_tb_top;
    reg core_clk_i = 1'h0, rst_i = 1'h1, irq_enable_bit_i = 1'h1, cpu_mask_i = 1'h0;
    reg [2:0] clock_rate_select_i = 3'h0;
    reg clock_idle_polarity_i = 1'h0, clock_sample_phase_i = 1'h0;
    reg select_soft_manage_i = 1'h1, select_soft_level_i = 1'h1;
    reg ctrl_wr_i = 1'h0, master_select_wr_i = 1'h0, peripheral_enable_wr_i = 1'h0;
    reg status_rd_i = 1'h0, status_wr_i = 1'h0, data_wr_i = 1'h0, data_rd_i = 1'h0;
    reg [7:0] data_wdata_i = 8'h00, rx;
    wire [7:0] data_rdata_o;
    wire master_select_bit_o, peripheral_enable_bit_o, transfer_done_flag_o, mode_fault_flag_o;
    wire overrun_flag_o, write_collision_flag_o, irq_req_o, busy_o, sck_o, sck_oe_o;
    wire mosi_o, mosi_oe_o, miso_o, miso_oe_o, p_sck, p_mosi, p_miso, select_n_i;
    wire sck_i = sck_oe_o ? sck_o : p_sck; // pin level from both drivers
    wire mosi_i = mosi_oe_o ? mosi_o : p_mosi;
    wire miso_i = miso_oe_o ? miso_o : p_miso;
    reg [7:0] exp_q[$]; // expected received bytes
    reg [31:0] seed = 32'h511b_ed11;
    integer fails = 0, num_checks = 0, m, n;
    spims_core uut (.*);
    spims_peer peer (.sck_w(sck_i), .mosi_w(mosi_i), .miso_w(miso_i), .sck_o(p_sck), .mosi_o(p_mosi),
        .miso_o(p_miso), .sel_n_o(select_n_i));
    initial forever #12.5 core_clk_i = ~core_clk_i;
    task step;
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
    endtask
    task tick;
        @(posedge core_clk_i);
        #1;
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk1(input got, input exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    // one software access: strobes for one edge, then a quiet edge
    task sw(input cw, input sr, input dw, input dr, input [7:0] d);
        ctrl_wr_i = cw;
        master_select_wr_i = d[1];
        peripheral_enable_wr_i = d[0];
        status_rd_i = sr;
        data_wr_i = dw;
        data_rd_i = dr;
        data_wdata_i = d;
        tick;
        {ctrl_wr_i, status_rd_i, data_wr_i, data_rd_i} = 4'h0;
        tick;
    endtask
    // retime with the port disabled first
    task cfg(input p, input h, input s);
        sw(1'h1, 1'h0, 1'h0, 1'h0, 8'h00);
        clock_idle_polarity_i = p;
        clock_sample_phase_i = h;
        select_soft_manage_i = s;
        select_soft_level_i = 1'h1;
        peer.setup(p, h, s);
        tick;
    endtask
    // master byte: half period, a colliding write, then the far side's capture
    task mxfer(input [7:0] tx, input [7:0] st, input note);
        peer.load(st);
        if (note)
            exp_q.push_back(st);
        data_wdata_i = tx;
        data_wr_i = 1'h1;
        tick;
        data_wr_i = 1'h0;
        for (n = 0; n < 300 && sck_o === clock_idle_polarity_i; n = n + 1) tick;
        for (n = 0; n < 300 && sck_o !== clock_idle_polarity_i; n = n + 1) tick;
        chk(n[7:0], 8'h02 << (clock_rate_select_i > 3'h5 ? 3'h5 : clock_rate_select_i));
        data_wdata_i = ~tx;
        data_wr_i = 1'h1;
        tick;
        data_wr_i = 1'h0;
        for (n = 0; n < 3000 && busy_o !== 1'h0; n = n + 1) tick;
        repeat (3) tick;
        chk(peer.srx, tx);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // each new received byte is compared with the oldest note
    initial forever begin
        @(posedge transfer_done_flag_o);
        #2;
        if (exp_q.size() == 0)
            chk(data_rdata_o, ~data_rdata_o); // no note queued: count it as wrong
        else
            chk(data_rdata_o, exp_q.pop_front());
    end
    initial begin
        #1_000_000;
        fails = fails + 1;
        $display("MISMATCH t=%0t watchdog expired", $time);
        tally_and_finish;
    end
    initial begin
        repeat (20) @(posedge core_clk_i);
        #1 rst_i = 1'h0;
        repeat (3) tick;
        for (m = 0; m < 4; m = m + 1) begin
            cfg(m[1], m[0], 1'h1);
            step;
            // code zero skipped: miso through two sync stages lags a two-cycle half period
            clock_rate_select_i = (seed[2:0] == 3'h0) ? 3'h1 : seed[2:0];
            sw(1'h1, 1'h0, 1'h0, 1'h0, 8'h03);
            chk1(master_select_bit_o, 1'h1);
            mxfer(seed[15:8], seed[23:16], 1'h1);
            chk1(write_collision_flag_o, 1'h1);
            sw(1'h0, 1'h0, 1'h1, 1'h0, seed[31:24]);
            chk1(busy_o, 1'h0);
            chk1(write_collision_flag_o, 1'h1);
            sw(1'h0, 1'h1, 1'h0, 1'h0, 8'h00);
            sw(1'h0, 1'h0, 1'h0, 1'h1, 8'h00);
            chk1(transfer_done_flag_o, 1'h0);
            chk1(write_collision_flag_o, 1'h0);
            $display("test master mode %0d finished", m);
        end
        step;
        mxfer(8'ha5, seed[7:0], 1'h1);
        sw(1'h0, 1'h1, 1'h0, 1'h0, 8'h00);
        mxfer(8'h3c, seed[15:8], 1'h0);
        chk1(overrun_flag_o, 1'h1);
        chk1(irq_req_o, 1'h1);
        chk(data_rdata_o, seed[7:0]);
        sw(1'h0, 1'h1, 1'h0, 1'h0, 8'h00);
        chk1(overrun_flag_o, 1'h0);
        sw(1'h0, 1'h0, 1'h0, 1'h1, 8'h00);
        chk1(transfer_done_flag_o, 1'h0);
        $display("test overrun finished");
        sw(1'h1, 1'h0, 1'h0, 1'h0, 8'h03);
        select_soft_level_i = 1'h0;
        repeat (2) tick;
        chk1(mode_fault_flag_o, 1'h1);
        chk1(peripheral_enable_bit_o, 1'h0);
        chk1(irq_req_o, 1'h1);
        cpu_mask_i = 1'h1;
        tick;
        chk1(irq_req_o, 1'h0);
        cpu_mask_i = 1'h0;
        select_soft_level_i = 1'h1;
        sw(1'h1, 1'h0, 1'h0, 1'h0, 8'h03);
        chk1(master_select_bit_o, 1'h0);
        sw(1'h0, 1'h1, 1'h0, 1'h0, 8'h00);
        sw(1'h1, 1'h0, 1'h0, 1'h0, 8'h03);
        chk1(mode_fault_flag_o, 1'h0);
        chk1(master_select_bit_o, 1'h1);
        $display("test mode fault finished");
        for (m = 0; m < 2; m = m + 1) begin
            step;
            cfg(seed[0], ~m[0], 1'h0);
            sw(1'h1, 1'h0, 1'h0, 1'h0, 8'h01);
            for (n = 0; n < 2; n = n + 1) begin
                step;
                sw(1'h0, 1'h1, 1'h0, 1'h0, 8'h00);
                sw(1'h0, 1'h0, 1'h1, 1'h0, seed[7:0]);
                chk1(transfer_done_flag_o, 1'h0);
                exp_q.push_back(seed[15:8]);
                // phase one holds select low; phase zero raises it after the first byte only
                peer.xfer(seed[15:8], !clock_sample_phase_i && (n == 0), rx);
                repeat (4) tick;
                chk(rx, seed[7:0]);
                chk1(mode_fault_flag_o, 1'h0);
            end
            sw(1'h0, 1'h1, 1'h0, 1'h0, 8'h00);
            sw(1'h0, 1'h0, 1'h1, 1'h0, 8'h00);
            chk1(write_collision_flag_o, ~clock_sample_phase_i);
            peer.sel_n_o = 1'h1;
            $display("test slave phase %0d finished", clock_sample_phase_i);
        end
        n = exp_q.size();
        chk(n[7:0], 8'h00);
        tally_and_finish;
    end
endmodule
